/* File: verilog/cpch_uplink_framer.sv */
// Decided for this implementation: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`include "cpch_cfg.svh"

module cpch_uplink_framer
    import cpch_pkg::*;
#(
    parameter int CLK_PER_CHIP = `CLK_PER_CHIP
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    input  wire logic        bch_frame,
    input  wire logic        data_in,
    output logic             pre_chip,
    output logic             pre_valid,
    output logic [1:0]       scr_seg,
    output logic             ctl_bit,
    output logic             ctl_valid,
    output logic             data_bit,
    output logic             data_valid,
    output logic             slot_strobe,
    output logic             frame_strobe,
    output logic [3:0]       slot_index,
    output logic [2:0]       tx_phase
);

    // ==================================================
    // Slot format and pilot lookup.

    // Field sizes {pilot, power, format indicator, feedback} per format.
    function automatic logic [9:0] fmt_fields(input logic [2:0] f);
        case (f)
            3'h1:    return {4'h8, 2'h2, 2'h0, 2'h0};
            3'h2:    return {4'h5, 2'h2, 2'h2, 2'h1};
            3'h3:    return {4'h7, 2'h2, 2'h0, 2'h1};
            3'h4:    return {4'h6, 2'h2, 2'h0, 2'h2};
            3'h5:    return {4'h5, 2'h1, 2'h2, 2'h2};
            default: return {4'h6, 2'h2, 2'h2, 2'h0};
        endcase
    endfunction

    // Per-slot frame sync word; bit 0 is the first variable pilot bit.
    function automatic logic [3:0] sync_word(input logic [3:0] s);
        case (s)
            4'h0, 4'h5:  return 4'h7;
            4'h1:        return 4'h4;
            4'h2, 4'ha:  return 4'ha;
            4'h3:        return 4'h0;
            4'h4:        return 4'h9;
            4'h6:        return 4'h3;
            4'h7, 4'hc:  return 4'h1;
            4'h8:        return 4'h6;
            4'h9:        return 4'hf;
            4'hb:        return 4'hd;
            default:     return 4'hc;
        endcase
    endfunction

    // Pilot bit i for a pilot length of 5 to 8 bits in slot s.
    function automatic logic pilot_bit(input logic [3:0] np, input logic [3:0] s,
                                       input logic [2:0] i);
        logic [3:0] w;
        logic [7:0] p;
        w = sync_word(s);
        case (np)
            4'h5:    p = {3'h0, 1'b1, w[3], w[2], w[1], w[0]};
            4'h6:    p = {2'h0, 1'b1, w[3], w[2], w[1], w[0], 1'b1};
            4'h7:    p = {1'b0, 1'b1, w[3], w[2], 1'b1, w[1], w[0], 1'b1};
            default: p = {w[3], 1'b1, w[2], 1'b1, w[1], 1'b1, w[0], 1'b1};
        endcase
        return p[i];
    endfunction

    // Control bit b of a slot: pilot, format indicator, feedback, power.
    function automatic logic ctl_bit_f(input logic [2:0] f, input logic [3:0] b,
                                       input logic [3:0] s, input logic tpc,
                                       input logic [1:0] tf, input logic [1:0] fb);
        logic [3:0] np;
        logic [1:0] nt;
        logic [1:0] nc;
        logic [1:0] nf;
        logic [3:0] o;
        {np, nt, nc, nf} = fmt_fields(f);
        if (b < np) return pilot_bit(np, s, b[2:0]);
        o = b - np;
        if (o < {2'h0, nc}) return tf[o[0]];
        o = o - {2'h0, nc};
        if (o < {2'h0, nf}) return fb[o[0]];
        return tpc;
    endfunction

    // Byte-lane merge of a write into the current register word.
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) r[8*i +: 8] = nw[8*i +: 8];
        end
        return r;
    endfunction

    // ==================================================
    // State.
    phase_t      state;
    logic        bch_s1, bch_s2, bch_s3;
    logic [7:0]  div;
    logic        chip_en;
    logic [12:0] as_chip;
    logic        frame_par;
    logic [11:0] pc;
    logic [11:0] sc;
    logic [3:0]  slot;
    logic [7:0]  frame;
    logic [7:0]  frames_tgt;
    logic [3:0]  ap_left;
    logic        start, pcp8, ap_shared, tpc_cmd;
    logic [2:0]  slot_fmt, data_k;
    logic [3:0]  n_ap;
    logic [7:0]  max_frames, msg_frames;
    logic [15:0] ap_sig, cd_sig;
    logic [1:0]  tfci, fbi;
    logic [7:0]  aw_addr_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;
    logic        aw_full, w_full;
    logic        wr_go, bch_edge, as_tick, slot_end, burst;
    logic [31:0] cur_w, new_w, rd_w;
    logic [7:0]  dmask;

    assign wr_go    = aw_full && w_full && !bvalid;
    assign bch_edge = bch_s2 && !bch_s3;
    assign as_tick  = chip_en && as_chip == 13'(`CHIPS_ACC_SLOT - 1);
    assign slot_end = chip_en && sc == 12'(`CHIPS_SLOT - 1);
    assign burst    = state == ST_PCP || state == ST_MSG;
    assign dmask    = 8'hff >> data_k;

    // ==================================================
    // Broadcast frame pin synchroniser and chip-rate divider.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {bch_s1, bch_s2, bch_s3} <= 3'h0;
        end else begin
            bch_s1 <= bch_frame;
            bch_s2 <= bch_s1;
            bch_s3 <= bch_s2;
        end
    end

    // Chip enable pulses once every CLK_PER_CHIP clocks.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div     <= 8'h00;
            chip_en <= 1'b0;
        end else if (div == 8'(CLK_PER_CHIP - 1)) begin
            div     <= 8'h00;
            chip_en <= 1'b1;
        end else begin
            div     <= div + 8'h01;
            chip_en <= 1'b0;
        end
    end

    // Access slot timer, realigned on every second broadcast frame edge.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            as_chip   <= 13'h0;
            frame_par <= 1'b0;
        end else begin
            if (bch_edge) frame_par <= ~frame_par;
            if (bch_edge && !frame_par) begin
                as_chip <= 13'h0;
            end else if (as_tick) begin
                as_chip <= 13'h0;
            end else if (chip_en) begin
                as_chip <= as_chip + 13'h1;
            end
        end
    end

    // ==================================================
    // Attempt sequencer.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state      <= ST_IDLE;
            ap_left    <= 4'h0;
            pc         <= 12'h0;
            frames_tgt <= `RST_FRAMES;
        end else begin
            unique case (state)
                ST_IDLE: if (start) begin
                    state      <= ST_ARM;
                    ap_left    <= (n_ap == 4'h0) ? 4'h1 : n_ap;
                    frames_tgt <= (msg_frames == 8'h0) ? 8'h1 :
                                  (msg_frames > max_frames && max_frames != 8'h0)
                                  ? max_frames : msg_frames;
                end
                ST_ARM: if (as_tick) begin
                    pc    <= 12'h0;
                    state <= (ap_left != 4'h0) ? ST_ACC : ST_CD;
                end
                ST_ACC: if (chip_en) begin
                    pc <= pc + 12'h1;
                    if (pc == 12'(`CHIPS_PREAMBLE - 1)) begin
                        ap_left <= ap_left - 4'h1;
                        state   <= ST_ARM;
                    end
                end
                ST_CD: if (chip_en) begin
                    pc <= pc + 12'h1;
                    if (pc == 12'(`CHIPS_PREAMBLE - 1)) begin
                        state <= pcp8 ? ST_PCP : ST_MSG;
                    end
                end
                ST_PCP: if (slot_end && slot == 4'(`PCP_SLOTS - 1)) begin
                    state <= ST_MSG;
                end
                ST_MSG: if (slot_end && slot == 4'(`SLOTS_FRAME - 1)
                            && frame == frames_tgt - 8'h1) begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Slot chip, slot and frame counters of the burst.
    always_ff @(posedge aclk) begin
        if (!aresetn || !burst) begin
            sc    <= 12'h0;
            slot  <= 4'h0;
            frame <= 8'h0;
        end else if (slot_end) begin
            sc <= 12'h0;
            if (state == ST_PCP && slot == 4'(`PCP_SLOTS - 1)) begin
                slot <= 4'h0;
            end else if (slot == 4'(`SLOTS_FRAME - 1)) begin
                slot  <= 4'h0;
                frame <= frame + 8'h1;
            end else begin
                slot <= slot + 4'h1;
            end
        end else if (chip_en) begin
            sc <= sc + 12'h1;
        end
    end

    // ==================================================
    // Transmit outputs: preamble chips, control and data branches.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pre_chip   <= 1'b0;
            pre_valid  <= 1'b0;
            scr_seg    <= `SEG_SHARED;
            ctl_bit    <= 1'b0;
            ctl_valid  <= 1'b0;
            data_bit   <= 1'b0;
            data_valid <= 1'b0;
        end else begin
            pre_valid <= chip_en && (state == ST_ACC || state == ST_CD);
            pre_chip  <= (state == ST_CD) ? cd_sig[pc[3:0]] : ap_sig[pc[3:0]];
            scr_seg   <= (state == ST_CD) ? `SEG_CD :
                         (ap_shared ? `SEG_SHARED : `SEG_AP);
            ctl_valid <= chip_en && burst && sc[7:0] == 8'h00;
            ctl_bit   <= ctl_bit_f(slot_fmt, sc[11:8], slot, tpc_cmd, tfci, fbi);
            data_valid <= chip_en && state == ST_MSG && (sc[7:0] & dmask) == 8'h00;
            data_bit   <= data_in;
        end
    end

    // Slot and frame strobes mark power control periods.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            slot_strobe  <= 1'b0;
            frame_strobe <= 1'b0;
            slot_index   <= 4'h0;
            tx_phase     <= 3'h0;
        end else begin
            slot_strobe  <= slot_end && burst;
            frame_strobe <= slot_end && state == ST_MSG && slot == 4'(`SLOTS_FRAME - 1);
            slot_index   <= slot;
            tx_phase     <= state;
        end
    end

    // ==================================================
    // Register bus slave.

    // Current word of a register, shared by reads and merged writes.
    function automatic logic [31:0] reg_word(input logic [7:0] a);
        case (a)
            `OFF_CTRL: return {29'h0, ap_shared, pcp8, 1'b0};
            `OFF_FMT:  return {msg_frames, max_frames, 4'h0, n_ap, 1'b0, data_k,
                               1'b0, slot_fmt};
            `OFF_SIG:  return {cd_sig, ap_sig};
            `OFF_FLD:  return {27'h0, fbi, tfci, tpc_cmd};
            `OFF_STAT: return {12'h0, ap_left, frame, slot, state != ST_IDLE, state};
            default:   return 32'h0;
        endcase
    endfunction

    // Current words for the pending write and the requested read.
    always_comb begin
        cur_w = reg_word(aw_addr_q);
        new_w = merge(cur_w, wdata_q, wstrb_q);
        rd_w  = reg_word({araddr[7:2], 2'h0});
    end

    // Write address and data are taken in either order; answer follows both.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {awready, wready, aw_full, w_full, bvalid} <= 5'h0;
            aw_addr_q <= 8'h00;
            wdata_q   <= 32'h0;
            wstrb_q   <= 4'h0;
            bresp     <= `RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                aw_addr_q <= {awaddr[7:2], 2'h0};
                aw_full   <= 1'b1;
                awready   <= 1'b0;
            end else if (!aw_full && !bvalid) begin
                awready <= 1'b1;
            end
            if (wvalid && wready) begin
                wdata_q <= wdata;
                wstrb_q <= wstrb;
                w_full  <= 1'b1;
                wready  <= 1'b0;
            end else if (!w_full && !bvalid) begin
                wready <= 1'b1;
            end
            if (wr_go) begin
                aw_full <= 1'b0;
                w_full  <= 1'b0;
                bvalid  <= 1'b1;
                bresp   <= (aw_addr_q > `OFF_STAT) ? `RESP_SLVERR : `RESP_OKAY;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // Configuration registers; start is a one-clock pulse.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {start, pcp8, ap_shared, tpc_cmd} <= 4'h0;
            {slot_fmt, data_k} <= 6'h0;
            n_ap       <= `RST_NAP;
            max_frames <= `RST_FRAMES;
            msg_frames <= `RST_FRAMES;
            {ap_sig, cd_sig} <= 32'h0;
            {tfci, fbi} <= 4'h0;
        end else begin
            start <= 1'b0;
            if (wr_go) begin
                case (aw_addr_q)
                    `OFF_CTRL: begin
                        start     <= new_w[`CTRL_START] && state == ST_IDLE;
                        pcp8      <= new_w[`CTRL_PCP8];
                        ap_shared <= new_w[`CTRL_APSHR];
                    end
                    `OFF_FMT: begin
                        slot_fmt   <= (new_w[`FMT_SLOT +: 3] > 3'h5) ? 3'h0
                                      : new_w[`FMT_SLOT +: 3];
                        data_k     <= (new_w[`FMT_K +: 3] > 3'(`DATA_K_MAX))
                                      ? 3'(`DATA_K_MAX) : new_w[`FMT_K +: 3];
                        n_ap       <= new_w[`FMT_NAP +: 4];
                        max_frames <= new_w[`FMT_MAXF +: 8];
                        msg_frames <= new_w[`FMT_MSGF +: 8];
                    end
                    `OFF_SIG: begin
                        ap_sig <= new_w[15:0];
                        cd_sig <= new_w[`SIG_CD +: 16];
                    end
                    `OFF_FLD: begin
                        tpc_cmd <= new_w[`FLD_TPC];
                        tfci    <= new_w[`FLD_TFCI +: 2];
                        fbi     <= new_w[`FLD_FBI +: 2];
                    end
                    default: ;
                endcase
            end
        end
    end

    // Read channel answers one clock after the address is taken.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= 32'h0;
            rresp   <= `RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= rd_w;
            rresp   <= ({araddr[7:2], 2'h0} > `OFF_STAT) ? `RESP_SLVERR : `RESP_OKAY;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end else if (!rvalid) begin
            arready <= 1'b1;
        end
    end

    // ==================================================
    // Checks.

    // Clocks since the last control bit; a longer gap means a control bit was lost.
    logic [15:0] ctl_gap;
    always_ff @(posedge aclk) begin
        if (!aresetn || !burst || ctl_valid) begin
            ctl_gap <= 16'h0;
        end else begin
            ctl_gap <= ctl_gap + 16'h1;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_ap_length: assert property (state == ST_ACC && chip_en && pc == 12'hfff
                                  |=> state == ST_ARM) else $error("ap length");
    a_cd_after_ap: assert property ($rose(state == ST_CD) |-> ap_left == 4'h0
                                  && $past(state) == ST_ARM) else $error("cd order");
    a_pcp_skip: assert property ($rose(state == ST_MSG) && $past(state) == ST_CD
                                  |-> !pcp8) else $error("pcp skipped");
    a_start_slot: assert property ($rose(state == ST_ACC) |-> as_chip == 13'h0)
                                  else $error("start off slot");
    a_as_spacing: assert property (as_tick && !bch_edge |=> as_chip == 13'h0)
                                  else $error("slot spacing");
    a_sig_chip: assert property (state == ST_ACC && chip_en |=> pre_valid
                                  && pre_chip == $past(ap_sig[pc[3:0]]))
                                  else $error("sig chip");
    a_cd_segment: assert property (state == ST_CD && chip_en |=> scr_seg == `SEG_CD)
                                  else $error("cd segment");
    a_frame_max: assert property (state == ST_MSG && max_frames != 8'h0
                                  |-> frame < max_frames) else $error("frames");
    a_slot_len: assert property (slot_strobe |-> $past(sc, 1) == 12'h9ff)
                                  else $error("slot length");
    a_ctl_rate: assert property (ctl_gap < 16'(`CTL_SF * CLK_PER_CHIP))
                                  else $error("ctl rate");
    a_slot_restart: assert property (frame_strobe |-> ##1 slot == 4'h0)
                                  else $error("slot restart");

    c_pcp_burst: cover property ($rose(state == ST_PCP));
    c_msg_end:   cover property ($fell(state == ST_MSG));
    c_two_ap:    cover property ($rose(state == ST_ACC) && ap_left > 4'h1);

endmodule

/* File: inc/cpch_cfg.svh */
`ifndef CPCH_CFG_SVH
`define CPCH_CFG_SVH

// ==================================================
// Timing of the uplink packet channel, in chips unless the name gives another unit.
`define CLK_HZ          50000000
`define CHIP_HZ         3840000
`define CLK_PER_CHIP    (`CLK_HZ / `CHIP_HZ)
`define CHIPS_PREAMBLE  4096
`define CHIPS_ACC_SLOT  5120
`define ACC_SLOTS       15
`define CHIPS_SLOT      2560
`define SLOTS_FRAME     15
`define FRAME_MS        10
`define SIG_LEN         16
`define CTL_SF          256
`define CTL_BITS        10
`define PCP_SLOTS       8
`define DATA_K_MAX      6

// ==================================================
// Register byte offsets.
`define OFF_CTRL        8'h00
`define OFF_FMT         8'h04
`define OFF_SIG         8'h08
`define OFF_FLD         8'h0c
`define OFF_STAT        8'h10

// ==================================================
// Field positions and reset values.
`define CTRL_START      0
`define CTRL_PCP8       1
`define CTRL_APSHR      2
`define FMT_SLOT        0
`define FMT_K           4
`define FMT_NAP         8
`define FMT_MAXF        16
`define FMT_MSGF        24
`define SIG_CD          16
`define FLD_TPC         0
`define FLD_TFCI        1
`define FLD_FBI         3
`define RST_NAP         4'h1
`define RST_FRAMES      8'h01

// ==================================================
// Scrambling segment codes and bus answers.
`define SEG_SHARED      2'h0
`define SEG_AP          2'h1
`define SEG_CD          2'h2
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

/* File: inc/cpch_pkg.sv */
package cpch_pkg;

    // ==================================================
    // Phases of one access attempt.
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ARM,
        ST_ACC,
        ST_CD,
        ST_PCP,
        ST_MSG
    } phase_t;

endpackage

/* File: sim/cpch_rx_model.sv */
`timescale 1ns/100ps
// ==================================================
// Cell receiver: broadcast frame timing and stream counters.
module cpch_rx_model #(
    parameter int CLK_PER_CHIP = 1
) (
    input  wire logic        aclk,
    input  wire logic        pre_chip,
    input  wire logic        pre_valid,
    input  wire logic [1:0]  scr_seg,
    input  wire logic        ctl_bit,
    input  wire logic        ctl_valid,
    input  wire logic        data_valid,
    input  wire logic        slot_strobe,
    input  wire logic        frame_strobe,
    input  wire logic [3:0]  slot_index,
    input  wire logic [2:0]  tx_phase,
    input  wire logic [31:0] sig,
    output logic             bch_frame
);
    int fcnt = 0;
    int pc = 0;
    int n_pre = 0, n_ctl = 0, n_dat = 0, n_slot = 0, n_frm = 0, n_bad = 0;
    logic cd;
    assign cd = (tx_phase == 3'h3);
    // The broadcast frame edge repeats every 38400 chips.
    always @(posedge aclk) begin
        fcnt <= (fcnt == 38400 * CLK_PER_CHIP - 1) ? 0 : fcnt + 1;
        bch_frame <= (fcnt < 8);
    end
    // Counts the units and flags any chip or segment off its value, and control bits of slots 0 and 9 or at bits 8 and 9.
    always @(posedge aclk) begin
        pc <= pre_valid ? pc + 1 : 0;
        n_pre <= n_pre + pre_valid;
        n_dat <= n_dat + data_valid;
        n_slot <= n_slot + slot_strobe;
        n_frm <= n_frm + frame_strobe;
        if (pre_valid && (pre_chip !== sig[(cd ? 16 : 0) + pc % 16]
            || scr_seg !== (cd ? 2'h2 : 2'h1))) begin
            n_bad <= n_bad + 1;
        end
        if (ctl_valid) begin
            n_ctl <= n_ctl + 1;
            if ((n_ctl % 10 >= 8 || slot_index == 4'h0 || slot_index == 4'h9)
                && ctl_bit !== (n_ctl % 10 != 7 || slot_index == 4'h9)) begin
                n_bad <= n_bad + 1;
            end
        end
    end
endmodule

/* File: sim/tb_cpch_uplink_framer.sv */
`timescale 1ns/100ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_fail++; \
    $display("ERROR %0t got %0h expected %0h", $time, (a), (e)); end end
module tb_cpch_uplink_framer;
    localparam logic [31:0] SIG = 32'h5a3c_c3a5;
    localparam logic [31:0] FMT = 32'h0201_0121;
    logic        aclk, aresetn = 1'b0, data_in = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0]  wstrb = 4'hf;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, pre_chip, pre_valid, ctl_bit;
    logic        ctl_valid, data_valid, data_bit, slot_strobe, frame_strobe;
    logic [1:0]  bresp, rresp, scr_seg;
    logic [3:0]  slot_index;
    logic [2:0]  tx_phase;
    wire logic   bch_frame;
    int          n_fail = 0, n_compared = 0, cyc = 0;
    cpch_uplink_framer #(.CLK_PER_CHIP(1)) dut_u (.*);
    cpch_rx_model #(.CLK_PER_CHIP(1)) rx_u (.*, .sig(SIG));
    // ==================================================
    // Clock, data stream and run limit.
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    // The data bit must be the input taken at the edge that raised data_valid.
    always @(posedge aclk) begin
        if (data_valid) `CHK(data_bit, ~data_in)
        data_in <= ~data_in;
        cyc <= cyc + 1;
        if (cyc == 95000) begin
            n_fail++;
            wrap_up();
        end
    end
    // ==================================================
    // Bus tasks and closing report.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        {awvalid, wvalid, bready} <= 3'h7;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        `CHK(bresp, e)
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e,
                      input logic [31:0] m);
        @(posedge aclk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        `CHK(rdata & m, d)
        `CHK(rresp, e)
    endtask
    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // ==================================================
    // Main sequence: registers, then one attempt with an eight-slot power preamble.
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rd(8'h04, 32'h0101_0100, 2'h0, '1);
        rd(8'h14, 32'h0, 2'h2, '1);
        wr(8'h14, 32'h1, 2'h2);
        wr(8'h08, SIG, 2'h0);
        wr(8'h0c, 32'h1, 2'h0);
        wr(8'h04, FMT, 2'h0);
        rd(8'h04, FMT, 2'h0, '1);
        wr(8'h00, 32'h3, 2'h0);
        rd(8'h10, 32'h8, 2'h0, 32'h8);
        wr(8'h00, 32'h3, 2'h0);
        while (tx_phase !== 3'h0) @(posedge aclk);
        `CHK(rx_u.n_pre, 8192)
        `CHK(rx_u.n_ctl, 230)
        `CHK(rx_u.n_dat, 600)
        `CHK(rx_u.n_slot, 23)
        `CHK(rx_u.n_frm, 1)
        `CHK(rx_u.n_bad, 0)
        wrap_up();
    end
endmodule
